//--- rtl/loop_clock_cfg_pkg.sv
// Package: register map, field positions and reset values of the dual loop clock configuration
// Function
// - Decode loop configuration registers in address range 0x0300 through 0x0363.
// - First loop control: bypass b0, dither b1, reset b2, gated b4, lock b5.
// - First loop feedback divider: hi bits 1:0 plus full low register, 10 bits.
// - First loop 20-bit fraction: low nibble then two full registers, MSB first.
// - Spread enable b0, fast spread b1, fraction enable b2; all clear at reset.
// - Lock detector clear b1, external enable b0, 2-bit count and precision fields.
// - Serial output divider 3 bits and M divider 4 bits in low bits.
// - Second loop control: bypass b0, divider reset sync b1, reset b2; resets 0x12.
// - Second loop feedback divider: hi bits 1:0 plus full following register.
// - Memory clock divides by one plus its 4-bit field.
// - Converter clock divides by one plus its 4-bit field.
// - System clock predivider divides by one plus its 4-bit field.
// - System divider codes 0..13 map to 1,1.5,2..4.5,5,6,7,8,9,10 ascending; codes 14 and 15 give 1.
// - Processor predivider one plus field; divider uses system fractional ratio code.
// - Memory predivider divides by one plus its 2-bit field.
// - ADC and converter reference predividers divide by one plus one bit.
// - ADC post-divide mode 0 gives 1+field, mode 1 gives 2*(1+field).
// - Serial width: 3-bit select, manual enable b6, manual width b5:4.
// - Smooth VCO latch enables b0..b2 per loop; b3 selection for first loop.
package loop_clock_cfg_pkg;

   // ==========================================================
   // Map geometry
   localparam int          ADDR_W     = 16;
   localparam int          DATA_W     = 8;
   localparam int          NUM_REGS   = 40;
   localparam logic [15:0] RANGE_LO   = 16'h0300;
   localparam logic [15:0] RANGE_HI   = 16'h0363;

   // ==========================================================
   // Register offsets, writable masks and reset values (table order)
   localparam logic [15:0] REG_ADDR [NUM_REGS] = '{
      16'h0300, 16'h0301, 16'h0302, 16'h0303, 16'h0304, 16'h0305, 16'h0306, 16'h0307,
      16'h0308, 16'h0309, 16'h0310, 16'h0311, 16'h0312, 16'h0313, 16'h0314, 16'h0315,
      16'h0316, 16'h0317, 16'h0318, 16'h0320, 16'h0321, 16'h0322, 16'h0323, 16'h0324,
      16'h0325, 16'h0326, 16'h0327, 16'h0329, 16'h032a, 16'h032b, 16'h032c, 16'h032d,
      16'h032e, 16'h032f, 16'h0330, 16'h0331, 16'h0360, 16'h0361, 16'h0362, 16'h0363};
   localparam logic [7:0] REG_RESET [NUM_REGS] = '{
      8'h3a, 8'hc8, 8'h21, 8'h01, 8'h01, 8'h2c, 8'h04, 8'h01,
      8'h13, 8'h03, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h12, 8'h31, 8'h03, 8'h04, 8'h00,
      8'hc8, 8'h09, 8'h04, 8'h01, 8'h04, 8'h06, 8'h03, 8'h01,
      8'h00, 8'h00, 8'h09, 8'h04, 8'h09, 8'h00, 8'h6a, 8'hc0};
   // Bits marked not used or reserved are cleared here and hold reset value
   localparam logic [7:0] REG_WMASK [NUM_REGS] = '{
      8'h3f, 8'hc8, 8'h37, 8'h07, 8'h03, 8'hff, 8'h07, 8'h0f,
      8'h13, 8'hf3, 8'h0f, 8'h07, 8'h07, 8'h0f, 8'hff, 8'hff,
      8'hff, 8'hff, 8'h0f, 8'hf7, 8'h37, 8'hf2, 8'h07, 8'h03,
      8'hff, 8'hff, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h03, 8'h01,
      8'h01, 8'h0f, 8'h0f, 8'h0f, 8'h77, 8'h0f, 8'hff, 8'hc0};

   // ==========================================================
   // Register indices used by the decode logic
   localparam int IX_A_CTRL   = 0;
   localparam int IX_A_FB_HI  = 4;
   localparam int IX_A_FB_LO  = 5;
   localparam int IX_A_SER    = 6;
   localparam int IX_A_M      = 7;
   localparam int IX_A_LOCK   = 9;
   localparam int IX_A_SSC    = 11;
   localparam int IX_A_FR_HI  = 13;
   localparam int IX_A_FR_MID = 14;
   localparam int IX_A_FR_LO  = 15;
   localparam int IX_B_CTRL   = 19;
   localparam int IX_B_FB_HI  = 23;
   localparam int IX_B_FB_LO  = 24;
   localparam int IX_B_ADC    = 25;
   localparam int IX_B_MEM    = 26;
   localparam int IX_B_CONV   = 27;
   localparam int IX_B_SYSPRE = 28;
   localparam int IX_B_SYS    = 29;
   localparam int IX_B_MEMPRE = 30;
   localparam int IX_B_ADCPRE = 31;
   localparam int IX_B_CNVPRE = 32;
   localparam int IX_B_CPUPRE = 34;
   localparam int IX_B_CPU    = 35;
   localparam int IX_SERWIDTH = 36;
   localparam int IX_LATCH    = 37;

   // ==========================================================
   // Field positions
   localparam int BIT_BYPASS    = 0;
   localparam int BIT_DITHER    = 1;
   localparam int BIT_SYNC      = 1;
   localparam int BIT_LOOPRST   = 2;
   localparam int BIT_GATED     = 4;
   localparam int BIT_LOCKSEL   = 5;
   localparam int BIT_SPREAD    = 0;
   localparam int BIT_FAST      = 1;
   localparam int BIT_FRAC      = 2;
   localparam int BIT_EXT       = 0;
   localparam int BIT_LDCLR     = 1;
   localparam int BIT_ADCMODE   = 4;
   localparam int BIT_MANUAL    = 6;
   localparam int BIT_LATCHSEL  = 3;

   // ==========================================================
   // Ratios are carried in half units so that 1.5 and friends stay integral
   localparam int RATIO_W = 6;
   localparam logic [RATIO_W-1:0] HALF_RATIO [16] = '{
      6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09,
      6'h0a, 6'h0c, 6'h0e, 6'h10, 6'h12, 6'h14, 6'h02, 6'h02};

   // ==========================================================
   // Grouped outputs
   typedef struct packed {
      logic       bypass;
      logic       dither;
      logic       loopReset;
      logic       gatedSel;
      logic       lockSel;
      logic [9:0] feedbackDiv;
      logic [19:0] fraction;
      logic       spreadOn;
      logic       spreadFast;
      logic       fractionOn;
      logic       lockdetClear;
      logic       externalOn;
      logic [1:0] countRef;
      logic [1:0] precision;
      logic [2:0] serialDiv;
      logic [3:0] mDiv;
   } first_loop_t;

   typedef struct packed {
      logic       bypass;
      logic       divresetSync;
      logic       loopReset;
      logic [9:0] feedbackDiv;
      logic [4:0] memoryRatio;
      logic [4:0] converterRatio;
      logic [4:0] systemPreRatio;
      logic [RATIO_W-1:0] systemHalfRatio;
      logic [2:0] memoryPreRatio;
      logic [1:0] adcPreRatio;
      logic [1:0] converterPreRatio;
      logic [5:0] adcPostRatio;
      logic [4:0] cpuPreRatio;
      logic [RATIO_W-1:0] cpuHalfRatio;
   } second_loop_t;

   typedef struct packed {
      logic [2:0] serialBitSel;
      logic       manualOn;
      logic [1:0] manualWidth;
      logic [2:0] latchOn;
      logic       latchChoice;
   } misc_cfg_t;

endpackage

//--- rtl/loop_clock_cfg.sv
// Register block and divider decode for the two on-chip clock loops
`timescale 1ns/1ns
module loop_clock_cfg
(
   input  wire logic                                      sys_clk,    // 250 MHz clock
   input  wire logic                                      resetn,     // Sync reset, low
   input  wire logic [loop_clock_cfg_pkg::ADDR_W-1:0]     regAddr,    // Register address
   input  wire logic                                      regWrite,   // Write strobe
   input  wire logic                                      regRead,    // Read strobe
   input  wire logic [loop_clock_cfg_pkg::DATA_W-1:0]     regWdata,   // Write data
   output logic      [loop_clock_cfg_pkg::DATA_W-1:0]     regRdata,   // Read data, registered
   output logic                                           regHit,     // Address in map
   output loop_clock_cfg_pkg::first_loop_t                firstLoop,  // First loop settings
   output loop_clock_cfg_pkg::second_loop_t               secondLoop, // Second loop settings
   output loop_clock_cfg_pkg::misc_cfg_t                  miscCfg     // Width and latch settings
);
   import loop_clock_cfg_pkg::*;

   // ==========================================================
   // Storage
   logic [7:0] regs_q [NUM_REGS];
   logic [7:0] rdata_q;

   // Address to table index; returns NUM_REGS when unmapped
   function automatic int find_index(input logic [15:0] a);
      int k;
      k = NUM_REGS;
      for (int i = 0; i < NUM_REGS; i++)
      begin
         if (REG_ADDR[i] == a)
         begin
            k = i;
         end
      end
      return k;
   endfunction

   // Divide by one plus a field value
   function automatic logic [5:0] plus_one(input logic [4:0] f);
      return 6'(f) + 6'h01;
   endfunction

   int hitIndex;
   logic inRange;

   // Decode only inside the loop block window; holes inside read zero
   always_comb
   begin
      inRange  = (regAddr >= RANGE_LO) && (regAddr <= RANGE_HI);
      hitIndex = inRange ? find_index(regAddr) : NUM_REGS;
   end

   assign regHit = (hitIndex != NUM_REGS);

   // ==========================================================
   // Register write; masked bits keep reset value whatever is written
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < NUM_REGS; i++)
         begin
            regs_q[i] <= REG_RESET[i];
         end
      end
      else if (regWrite && regHit)
      begin
         for (int i = 0; i < NUM_REGS; i++)
         begin
            if (i == hitIndex)
            begin
               regs_q[i] <= (regWdata & REG_WMASK[i])
                          | (REG_RESET[i] & ~REG_WMASK[i]);
            end
         end
      end
   end

   // ==========================================================
   // Read data is registered; unmapped reads return zero
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         rdata_q <= 8'h00;
      end
      else if (regRead)
      begin
         rdata_q <= 8'h00;
         for (int i = 0; i < NUM_REGS; i++)
         begin
            if (i == hitIndex)
            begin
               rdata_q <= regs_q[i];
            end
         end
      end
   end

   assign regRdata = rdata_q;

   // ==========================================================
   // First loop fields
   always_comb
   begin
      firstLoop.bypass       = regs_q[IX_A_CTRL][BIT_BYPASS];
      firstLoop.dither       = regs_q[IX_A_CTRL][BIT_DITHER];
      firstLoop.loopReset    = regs_q[IX_A_CTRL][BIT_LOOPRST];
      firstLoop.gatedSel     = regs_q[IX_A_CTRL][BIT_GATED];
      firstLoop.lockSel      = regs_q[IX_A_CTRL][BIT_LOCKSEL];
      firstLoop.feedbackDiv  = {regs_q[IX_A_FB_HI][1:0], regs_q[IX_A_FB_LO]};
      firstLoop.fraction     = {regs_q[IX_A_FR_HI][3:0], regs_q[IX_A_FR_MID],
                                regs_q[IX_A_FR_LO]};
      firstLoop.spreadOn     = regs_q[IX_A_SSC][BIT_SPREAD];
      firstLoop.spreadFast   = regs_q[IX_A_SSC][BIT_FAST];
      firstLoop.fractionOn   = regs_q[IX_A_SSC][BIT_FRAC];
      firstLoop.lockdetClear = regs_q[IX_A_LOCK][BIT_LDCLR];
      firstLoop.externalOn   = regs_q[IX_A_LOCK][BIT_EXT];
      firstLoop.countRef     = regs_q[IX_A_LOCK][5:4];
      firstLoop.precision    = regs_q[IX_A_LOCK][7:6];
      firstLoop.serialDiv    = regs_q[IX_A_SER][2:0];
      firstLoop.mDiv         = regs_q[IX_A_M][3:0];
   end

   // ==========================================================
   // Second loop fields and divider ratios
   // Ratios are presented already decoded so the divider chain needs no lookup
   always_comb
   begin
      secondLoop.bypass          = regs_q[IX_B_CTRL][BIT_BYPASS];
      secondLoop.divresetSync    = regs_q[IX_B_CTRL][BIT_SYNC];
      secondLoop.loopReset       = regs_q[IX_B_CTRL][BIT_LOOPRST];
      secondLoop.feedbackDiv     = {regs_q[IX_B_FB_HI][1:0], regs_q[IX_B_FB_LO]};
      secondLoop.memoryRatio     = 5'(plus_one({1'b0, regs_q[IX_B_MEM][3:0]}));
      secondLoop.converterRatio  = 5'(plus_one({1'b0, regs_q[IX_B_CONV][3:0]}));
      secondLoop.systemPreRatio  = 5'(plus_one({1'b0, regs_q[IX_B_SYSPRE][3:0]}));
      secondLoop.systemHalfRatio = HALF_RATIO[regs_q[IX_B_SYS][3:0]];
      secondLoop.cpuPreRatio     = 5'(plus_one({1'b0, regs_q[IX_B_CPUPRE][3:0]}));
      secondLoop.cpuHalfRatio    = HALF_RATIO[regs_q[IX_B_CPU][3:0]];
      secondLoop.memoryPreRatio  = 3'(plus_one({3'b000, regs_q[IX_B_MEMPRE][1:0]}));
      secondLoop.adcPreRatio     = 2'(plus_one({4'h0, regs_q[IX_B_ADCPRE][0]}));
      secondLoop.converterPreRatio = 2'(plus_one({4'h0, regs_q[IX_B_CNVPRE][0]}));
      // Mode bit doubles the ratio rather than adding a second divider stage
      if (regs_q[IX_B_ADC][BIT_ADCMODE])
      begin
         secondLoop.adcPostRatio = 6'(plus_one({1'b0, regs_q[IX_B_ADC][3:0]}) << 1);
      end
      else
      begin
         secondLoop.adcPostRatio = plus_one({1'b0, regs_q[IX_B_ADC][3:0]});
      end
   end

   // ==========================================================
   // Serial width and smooth change latches
   always_comb
   begin
      miscCfg.serialBitSel = regs_q[IX_SERWIDTH][2:0];
      miscCfg.manualOn     = regs_q[IX_SERWIDTH][BIT_MANUAL];
      miscCfg.manualWidth  = regs_q[IX_SERWIDTH][5:4];
      miscCfg.latchOn      = regs_q[IX_LATCH][2:0];
      miscCfg.latchChoice  = regs_q[IX_LATCH][BIT_LATCHSEL];
   end

endmodule

//--- test/loop_clock_cfg_assertions.sv
// Port checker for the loop clock configuration block
`timescale 1ns/1ns
module loop_clock_cfg_assertions
   import loop_clock_cfg_pkg::*;
(
   input wire logic                                  sys_clk,    // Clock
   input wire logic                                  resetn,     // Sync reset, low
   input wire logic [loop_clock_cfg_pkg::ADDR_W-1:0] regAddr,    // Address
   input wire logic                                  regWrite,   // Write strobe
   input wire logic                                  regRead,    // Read strobe
   input wire logic [loop_clock_cfg_pkg::DATA_W-1:0] regWdata,   // Write data
   input wire logic [loop_clock_cfg_pkg::DATA_W-1:0] regRdata,   // Read data
   input wire logic                                  regHit,     // Map hit
   input wire loop_clock_cfg_pkg::first_loop_t       firstLoop,  // First loop
   input wire loop_clock_cfg_pkg::second_loop_t      secondLoop, // Second loop
   input wire loop_clock_cfg_pkg::misc_cfg_t         miscCfg     // Misc fields
);
   // ==========================================================
   // Six write checks tie twelve decoded fields to the byte written a cycle before
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   a_outside_no_hit: assert property (
      (regAddr < 16'h0300 || regAddr > 16'h0363) |-> !regHit)
      else $error("hit outside map");
   a_unmapped_zero: assert property (regRead && !regHit |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!regRead |=> $stable(regRdata))
      else $error("read data moved without read");
   a_ctrl_a_bits: assert property (regWrite && regAddr == 16'h0300 |=>
      {firstLoop.lockSel, firstLoop.gatedSel, firstLoop.loopReset, firstLoop.dither,
      firstLoop.bypass} == {$past(regWdata[5:4]), $past(regWdata[2:0])})
      else $error("first loop control mismatch");
   a_spread_bits: assert property (regWrite && regAddr == 16'h0311 |=>
      {firstLoop.fractionOn, firstLoop.spreadFast, firstLoop.spreadOn} == $past(regWdata[2:0]))
      else $error("spread bits mismatch");
   a_fraction_low: assert property (regWrite && regAddr == 16'h0315 |=>
      firstLoop.fraction[7:0] == $past(regWdata))
      else $error("fraction low byte mismatch");
   a_fb_b_upper: assert property (regWrite && regAddr == 16'h0324 |=>
      secondLoop.feedbackDiv[9:8] == $past(regWdata[1:0]))
      else $error("second feedback upper mismatch");
   a_mem_ratio: assert property (regWrite && regAddr == 16'h0327 |=>
      secondLoop.memoryRatio == 5'($past(regWdata[3:0])) + 5'h01)
      else $error("memory ratio mismatch");
   a_adc_post: assert property (regWrite && regAddr == 16'h0326 |=>
      secondLoop.adcPostRatio == ((6'($past(regWdata[3:0])) + 6'h01) << $past(regWdata[4])))
      else $error("adc post ratio mismatch");
endmodule

bind loop_clock_cfg loop_clock_cfg_assertions loop_clock_cfg_assertions_i (.sys_clk(sys_clk),
   .resetn(resetn), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
   .regWdata(regWdata), .regRdata(regRdata), .regHit(regHit), .firstLoop(firstLoop),
   .secondLoop(secondLoop), .miscCfg(miscCfg));

//--- test/loop_clock_cfg_test.sv
// Self-checking bench for the loop clock configuration block
`timescale 1ns/1ns
module loop_clock_cfg_test;
   import loop_clock_cfg_pkg::*;
   logic sys_clk = 0, resetn = 0, regWrite = 0, regRead = 0, regHit;
   logic [15:0] regAddr = 16'h0000;
   logic [7:0] regWdata = 8'h00, regRdata;
   first_loop_t firstLoop;
   second_loop_t secondLoop;
   misc_cfg_t miscCfg;
   int errorCnt = 0, totalChecks = 0, cycles = 0;
   logic [7:0] rv;

   loop_clock_cfg loop_clock_cfg_i (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
      .regHit(regHit), .firstLoop(firstLoop), .secondLoop(secondLoop), .miscCfg(miscCfg));

   // ==========================================================
   // Clock, and a cycle ceiling so a stuck run still ends with a verdict
   initial forever #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errorCnt = errorCnt + 1;
         summarize();
      end
   end

   // ==========================================================
   // Bus cycles: strobe held one cycle, results sampled after the edge settles
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask
   task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
      totalChecks++;
      if (g !== e)
      begin
         errorCnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", totalChecks, errorCnt);
      if (errorCnt == 0 && totalChecks > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset_and_masks();
      for (int i = 0; i < NUM_REGS; i++)
      begin
         rd(REG_ADDR[i], rv);
         chk("reset value", REG_RESET[i], rv);
         wr(REG_ADDR[i], 8'hff);
         rd(REG_ADDR[i], rv);
         chk("ones readback", REG_RESET[i] | REG_WMASK[i], rv);
         wr(REG_ADDR[i], 8'h00);
         rd(REG_ADDR[i], rv);
         chk("zero readback", REG_RESET[i] & ~REG_WMASK[i], rv);
      end
      $display("test reset and masks done");
   endtask
   task automatic t_unmapped();
      wr(16'h0363, 8'h40);
      wr(16'h0364, 8'h80);
      wr(16'h0328, 8'hff);
      rd(16'h0363, rv);
      chk("speedup kept", 8'h40, rv);
      rd(16'h0328, rv);
      chk("gap read", 8'h00, rv);
      rd(16'h0364, rv);
      chk("above read", 8'h00, rv);
      chk("above hit", 1'b0, regHit);
      rd(16'h02ff, rv);
      chk("below read", 8'h00, rv);
      chk("below hit", 1'b0, regHit);
      rd(16'h0300, rv);
      chk("map hit", 1'b1, regHit);
      $display("test unmapped done");
   endtask
   // Field values are uneven so that a swapped bit position shows up
   task automatic t_first_loop();
      wr(16'h0300, 8'h13);
      chk("ctrl a", 5'b11010, {firstLoop.bypass, firstLoop.dither, firstLoop.loopReset,
         firstLoop.gatedSel, firstLoop.lockSel});
      wr(16'h0304, 8'h02);
      wr(16'h0305, 8'h5a);
      chk("fb a", 10'h25a, firstLoop.feedbackDiv);
      wr(16'h0313, 8'hfa);
      wr(16'h0314, 8'hbc);
      wr(16'h0315, 8'hde);
      chk("fraction", 20'habcde, firstLoop.fraction);
      wr(16'h0311, 8'h03);
      chk("spread", 3'b110, {firstLoop.spreadOn, firstLoop.spreadFast,
         firstLoop.fractionOn});
      wr(16'h0309, 8'he6);
      chk("lockdet", 6'b111010, {firstLoop.precision, firstLoop.countRef,
         firstLoop.lockdetClear, firstLoop.externalOn});
      wr(16'h0306, 8'hfd);
      wr(16'h0307, 8'hfc);
      chk("serial div", 3'h5, firstLoop.serialDiv);
      chk("m div", 4'hc, firstLoop.mDiv);
      $display("test first loop done");
   endtask
   task automatic t_second_loop();
      int h;
      wr(16'h0320, 8'h03);
      chk("ctrl b", 3'b110, {secondLoop.bypass, secondLoop.divresetSync,
         secondLoop.loopReset});
      wr(16'h0324, 8'h03);
      wr(16'h0325, 8'h01);
      chk("fb b", 10'h301, secondLoop.feedbackDiv);
      wr(16'h0327, 8'h0f);
      chk("memory", 5'd16, secondLoop.memoryRatio);
      wr(16'h0329, 8'h00);
      chk("converter", 5'd1, secondLoop.converterRatio);
      wr(16'h032a, 8'h0f);
      chk("sys pre", 5'd16, secondLoop.systemPreRatio);
      wr(16'h032c, 8'h03);
      chk("mem pre", 3'd4, secondLoop.memoryPreRatio);
      wr(16'h032d, 8'h01);
      chk("adc pre", 2'd2, secondLoop.adcPreRatio);
      wr(16'h032e, 8'h01);
      chk("conv pre", 2'd2, secondLoop.converterPreRatio);
      wr(16'h0330, 8'h0a);
      chk("cpu pre", 5'd11, secondLoop.cpuPreRatio);
      wr(16'h0326, 8'h1f);
      chk("adc post x2", 6'd32, secondLoop.adcPostRatio);
      wr(16'h0326, 8'h0f);
      chk("adc post x1", 6'd16, secondLoop.adcPostRatio);
      // Half steps below code 9, whole steps above; the two top codes fall back to one
      for (int c = 0; c < 16; c++)
      begin
         h = (c < 9) ? c + 2 : (c < 14) ? 2 * (c - 3) : 2;
         wr(16'h032b, 8'(c));
         wr(16'h0331, 8'(c));
         chk("sys div", 20'(h), secondLoop.systemHalfRatio);
         chk("cpu div", 20'(h), secondLoop.cpuHalfRatio);
      end
      $display("test second loop done");
   endtask
   task automatic t_misc();
      wr(16'h0360, 8'h6d);
      chk("serial width", 6'b101_1_10, {miscCfg.serialBitSel, miscCfg.manualOn,
         miscCfg.manualWidth});
      wr(16'h0361, 8'h0e);
      chk("latches", 4'b110_1, {miscCfg.latchOn, miscCfg.latchChoice});
      $display("test misc done");
   endtask
   // Reset in mid-run: written fields and the held read data must both fall back
   task automatic t_mid_reset();
      rd(16'h0360, rv);
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      #1;
      chk("rdata after reset", 8'h00, regRdata);
      chk("spread after reset", 3'b000, {firstLoop.spreadOn, firstLoop.spreadFast,
         firstLoop.fractionOn});
      rd(16'h0320, rv);
      chk("ctrl b after reset", 8'h12, rv);
      $display("test mid reset done");
   endtask

   initial
   begin
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      t_reset_and_masks();
      t_unmapped();
      t_first_loop();
      t_second_loop();
      t_misc();
      t_mid_reset();
      summarize();
   end
endmodule
